/* core_regfile_pkg.sv */
// Constants and types shared by the core register file and operand decoder
package core_regfile_pkg;
  localparam int REG_ADDR_W = 6;
  localparam int DATA_W = 32;
  localparam int COMPACT_W = 3;
  localparam int COND_W = 5;
  localparam int DEFAULT_NUM_REGS = 32;
  localparam int MAX_GP_REGS = 60;
  localparam int REDUCED_NUM_REGS = 16;
  localparam logic [5:0] REG_NULL = 6'h00;
  localparam logic [5:0] REG_STACK_PTR = 6'h1C;
  localparam logic [5:0] REG_LEVEL1_LINK = 6'h1D;
  localparam logic [5:0] REG_LEVEL2_LINK = 6'h1E;
  localparam logic [5:0] REG_CALL_LINK = 6'h1F;
  localparam logic [5:0] REG_LOOP_COUNTER = 6'h3C;
  localparam logic [5:0] REG_RESERVED = 6'h3D;
  localparam logic [5:0] REG_LONG_IMM = 6'h3E;
  localparam logic [5:0] REG_ALIGNED_PC = 6'h3F;
  localparam logic [5:0] COMPACT_HIGH_BASE = 6'h08;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hFFFFFFFC;
  localparam logic [31:0] CONFIG_INFO_FULL = 32'h00000000;
  localparam logic [31:0] CONFIG_INFO_REDUCED = 32'h00000001;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [4:0] COND_ALWAYS = 5'h00;
  localparam logic [4:0] NUM_PREDEFINED_COND = 5'h10;
  typedef enum logic [2:0] {
    OP_PLAIN, OP_BREAKPOINT, OP_SLEEP, OP_FLAG_WRITE, OP_SYNC, OP_AUX_STORE
  } op_class_e;
endpackage : core_regfile_pkg

/* core_register_file_decode.sv */
// Core register file with operand-field decode, flags and serialize control
`timescale 1ns/1ps
// Behaviour
// - Null destination discards result, flags still update
// - Flags change only with flag-writeback option
// - Five-bit condition gates execution; sixteen predefined
// - Serializing instruction completes, then pipeline flushes
// - Fuller variant: flag, sync, aux-store serialize
// - Thirty-two registers default, up to sixty
// - Compact codes map r0-r3 and r12-r15
// - Compact move/compare/add use full register field
// - Stack pointer r28 implicit for compact ops
// - r29/r30 interrupt links, r31 call link
// - Long immediate word supplied as source
// - r63 reads word-aligned program counter
// - Reduced sixteen-register option, reported by info
// - Reduced: absent writes ignored, reads zero
// - Reduced: load to absent register discards data
// - Fuller variant: unimplemented register raises error
// - Compact jumps always taken unconditionally
// - Position 62 decodes as long immediate
// - r63 read-only, low two bits zero
// - Fuller variant: r61 reference raises error
module core_register_file_decode
  import core_regfile_pkg::*;
#(
  parameter int NUM_REGS = DEFAULT_NUM_REGS,
  parameter bit REDUCED = 1'b0,
  parameter bit FULL_VARIANT = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Issue: operand fields
  input wire logic issueValid,
  input wire logic isCompact,
  input wire logic compactWideField,
  input wire logic useStackPtr,
  input wire logic [COMPACT_W-1:0] compactSrcA,
  input wire logic [COMPACT_W-1:0] compactSrcB,
  input wire logic [REG_ADDR_W-1:0] srcAField,
  input wire logic [REG_ADDR_W-1:0] srcBField,
  input wire logic [REG_ADDR_W-1:0] dstField,
  input wire logic [DATA_W-1:0] longImmWord,
  input wire logic [DATA_W-1:0] currentPc,
  input wire logic [COND_W-1:0] conditionField,
  input wire logic isJump,
  input wire op_class_e opClass,
  input wire logic [15:0] condTruth,
  input wire logic [15:0] extCondTruth,
  // Decode answers
  output logic [REG_ADDR_W-1:0] srcAReg,
  output logic [REG_ADDR_W-1:0] srcBReg,
  output logic [DATA_W-1:0] srcAData,
  output logic [DATA_W-1:0] srcBData,
  output logic needsLongImm,
  output logic condPass,
  output logic serialize,
  output logic instrError,
  output logic [DATA_W-1:0] regfileConfigInfo,
  // Writeback
  input wire logic wbValid,
  input wire logic [REG_ADDR_W-1:0] wbReg,
  input wire logic [DATA_W-1:0] wbData,
  input wire logic wbSetFlags,
  input wire logic [3:0] wbFlags,
  input wire logic wbIsLoad,
  input wire logic serialDone,
  // Status and control
  output logic [3:0] flags_q,
  output logic flushPending_q,
  output logic loadDiscarded
);
  import core_regfile_pkg::*;

  logic [DATA_W-1:0] regs_q [NUM_REGS];
  logic writeOk;
  logic [DATA_W-1:0] loopCount_q;
  logic [REG_ADDR_W-1:0] rdA, rdB;

  function automatic logic [5:0] mapCompact(input logic [2:0] code);
    // Codes 4..7 land on r12..r15 by adding an offset of eight
    return code[2] ? (6'(code) + COMPACT_HIGH_BASE) : 6'(code);
  endfunction : mapCompact

  function automatic logic implemented(input logic [5:0] r);
    if (REDUCED)
      return (r < 6'h04) || (r >= 6'h0A && r < 6'h10) || (r >= 6'h1A && r <= 6'h1F);
    return (r < 6'(NUM_REGS)) || (r == REG_LOOP_COUNTER);
  endfunction : implemented

  // Operand selection
  always_comb begin
    if (isCompact && !compactWideField) begin
      rdA = useStackPtr ? REG_STACK_PTR : mapCompact(compactSrcA);
      rdB = mapCompact(compactSrcB);
    end else begin
      rdA = srcAField;
      rdB = srcBField;
    end
  end
  assign srcAReg = rdA;
  assign srcBReg = rdB;

  function automatic logic [31:0] readReg(input logic [5:0] r);
    logic fwd;
    fwd = wbValid && (wbReg == r) && (r != REG_NULL) && implemented(r)
          && (r != REG_LOOP_COUNTER) && !(wbIsLoad && !implemented(r));
    if (r == REG_LONG_IMM)
      return longImmWord;
    if (r == REG_ALIGNED_PC)
      return currentPc & PC_ALIGN_MASK;
    if (!implemented(r) || r >= 6'(NUM_REGS) && r != REG_LOOP_COUNTER)
      return '0;
    // No bypass on the loop counter: readers see the old value for one cycle
    if (r == REG_LOOP_COUNTER)
      return loopCount_q;
    if (fwd)
      return wbData;
    return regs_q[r[$clog2(NUM_REGS)-1:0]];
  endfunction : readReg

  // Processes, not assigns: the reads inside readReg must wake them up
  always_comb srcAData = readReg(rdA);
  always_comb srcBData = readReg(rdB);
  assign needsLongImm = issueValid && ((rdA == REG_LONG_IMM) || (rdB == REG_LONG_IMM));

  // Condition evaluation; compact jumps ignore the field
  always_comb begin
    if (isCompact && isJump)
      condPass = 1'b1;
    else if (conditionField < NUM_PREDEFINED_COND)
      condPass = condTruth[conditionField[3:0]];
    else
      condPass = extCondTruth[conditionField[3:0]];
  end

  always_comb begin
    unique case (opClass)
      OP_BREAKPOINT, OP_SLEEP: serialize = issueValid;
      OP_FLAG_WRITE, OP_SYNC, OP_AUX_STORE: serialize = issueValid && FULL_VARIANT;
      default: serialize = 1'b0;
    endcase
  end

  // Errors only exist in the fuller variant; without FULL_VARIANT bad references fail silently
  assign instrError = FULL_VARIANT && issueValid &&
    ((rdA == REG_RESERVED) || (rdB == REG_RESERVED) || (dstField == REG_RESERVED)
     || (!implemented(rdA) && rdA < REG_RESERVED) || (!implemented(rdB) && rdB < REG_RESERVED)
     || (!implemented(dstField) && dstField < REG_RESERVED));

  assign regfileConfigInfo = REDUCED ? CONFIG_INFO_REDUCED : CONFIG_INFO_FULL;

  // r63 and r62 are never write targets; absent registers swallow writes
  assign writeOk = wbValid && (wbReg != REG_NULL) && implemented(wbReg)
                   && (wbReg < 6'(NUM_REGS) || wbReg == REG_LOOP_COUNTER)
                   && (wbReg != REG_ALIGNED_PC) && (wbReg != REG_LONG_IMM);
  assign loadDiscarded = wbValid && wbIsLoad && !implemented(wbReg);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : gRegs
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          regs_q[gi] <= '0;
        end else if (writeOk && wbReg == REG_ADDR_W'(gi)) begin
          regs_q[gi] <= wbData;
        end
      end
    end
  endgenerate

  // Loop counter has its own storage; r60 would otherwise alias a low register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      loopCount_q <= '0;
    end else if (writeOk && wbReg == REG_LOOP_COUNTER) begin
      loopCount_q <= wbData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_q <= FLAGS_RESET;
    end else if (wbValid && wbSetFlags) begin
      flags_q <= wbFlags;
    end
  end

  // Fetch waits on this until the serializing op reports completion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flushPending_q <= 1'b0;
    end else if (serialize) begin
      flushPending_q <= 1'b1;
    end else if (serialDone) begin
      flushPending_q <= 1'b0;
    end
  end

  property p_flags_hold;
    @(posedge clk) disable iff (sys_rst) !(wbValid && wbSetFlags) |=> $stable(flags_q);
  endproperty
  a_flags_hold: assert property (p_flags_hold) else $error("flags changed without writeback");
  property p_flags_null;
    @(posedge clk) disable iff (sys_rst)
      wbValid && wbSetFlags && wbReg == REG_NULL |=> flags_q == $past(wbFlags);
  endproperty
  a_flags_null: assert property (p_flags_null) else $error("null dest lost flag update");
  property p_pc_align;
    @(posedge clk) disable iff (sys_rst)
      rdA == REG_ALIGNED_PC |-> srcAData == {currentPc[31:2], 2'b00};
  endproperty
  a_pc_align: assert property (p_pc_align) else $error("aligned pc read wrong");
  property p_limm;
    @(posedge clk) disable iff (sys_rst) rdB == REG_LONG_IMM |-> srcBData == longImmWord;
  endproperty
  a_limm: assert property (p_limm) else $error("long immediate not supplied");
  property p_compact_map;
    @(posedge clk) disable iff (sys_rst) isCompact && !compactWideField && compactSrcB[2]
      |-> srcBReg == 6'(compactSrcB) + 6'h08;
  endproperty
  a_compact_map: assert property (p_compact_map) else $error("compact map wrong");
  property p_cjump;
    @(posedge clk) disable iff (sys_rst) isCompact && isJump |-> condPass;
  endproperty
  a_cjump: assert property (p_cjump) else $error("compact jump not taken");
  property p_serial;
    @(posedge clk) disable iff (sys_rst)
      issueValid && (opClass == OP_BREAKPOINT || opClass == OP_SLEEP) |-> serialize ##1 flushPending_q;
  endproperty
  a_serial: assert property (p_serial) else $error("serializing op not flagged");
  property p_write;
    @(posedge clk) disable iff (sys_rst)
      wbValid && wbReg == 6'h01 |=> regs_q[1] == $past(wbData);
  endproperty
  a_write: assert property (p_write) else $error("register write lost");
  property p_r61;
    @(posedge clk) disable iff (sys_rst)
      FULL_VARIANT && issueValid && rdA == REG_RESERVED |-> instrError;
  endproperty
  a_r61: assert property (p_r61) else $error("reserved register not trapped");
  property p_sp;
    @(posedge clk) disable iff (sys_rst)
      isCompact && !compactWideField && useStackPtr |-> srcAReg == REG_STACK_PTR;
  endproperty
  a_sp: assert property (p_sp) else $error("stack pointer not selected");

  // Checks on storage, flags, serialization, conditions, operand selection and the special positions
  property p_loop_no_fwd;
    @(posedge clk) disable iff (sys_rst)
      wbValid && wbReg == REG_LOOP_COUNTER && rdA == REG_LOOP_COUNTER
      |-> srcAData == loopCount_q;
  endproperty
  a_loop_no_fwd: assert property (p_loop_no_fwd) else $error("loop counter forwarded");
  property p_null_nowrite;
    @(posedge clk) disable iff (sys_rst)
      wbValid && wbReg == REG_NULL |=> regs_q[0] == $past(regs_q[0]);
  endproperty
  a_null_nowrite: assert property (p_null_nowrite) else $error("null dest written");
  property p_flags_set;
    @(posedge clk) disable iff (sys_rst) wbValid && wbSetFlags |=> flags_q == $past(wbFlags);
  endproperty
  a_flags_set: assert property (p_flags_set) else $error("flag writeback lost");
  property p_absent_read;
    @(posedge clk) disable iff (sys_rst)
      !implemented(rdA) && rdA < REG_RESERVED |-> srcAData == 32'h00000000;
  endproperty
  a_absent_read: assert property (p_absent_read) else $error("absent read nonzero");
  property p_load_discard;
    @(posedge clk) disable iff (sys_rst) loadDiscarded |-> !writeOk;
  endproperty
  a_load_discard: assert property (p_load_discard) else $error("discarded load wrote");
  property p_serial_ext;
    @(posedge clk) disable iff (sys_rst) FULL_VARIANT && issueValid && (opClass == OP_FLAG_WRITE
      || opClass == OP_SYNC || opClass == OP_AUX_STORE) |-> serialize;
  endproperty
  a_serial_ext: assert property (p_serial_ext) else $error("op not serialized");
  property p_flush_hold;
    @(posedge clk) disable iff (sys_rst) flushPending_q && !serialDone |=> flushPending_q;
  endproperty
  a_flush_hold: assert property (p_flush_hold) else $error("flush released early");
  property p_cond_ext;
    @(posedge clk) disable iff (sys_rst) !(isCompact && isJump) && conditionField[4]
      |-> condPass == extCondTruth[conditionField[3:0]];
  endproperty
  a_cond_ext: assert property (p_cond_ext) else $error("extension condition ignored");
  property p_pc_bits;
    @(posedge clk) disable iff (sys_rst) srcBReg == REG_ALIGNED_PC |-> srcBData[1:0] == 2'h0;
  endproperty
  a_pc_bits: assert property (p_pc_bits) else $error("pc low bits not zero");
  property p_wide;
    @(posedge clk) disable iff (sys_rst)
      isCompact && compactWideField |-> srcAReg == srcAField && srcBReg == srcBField;
  endproperty
  a_wide: assert property (p_wide) else $error("wide field not used");

  c_limm: cover property (@(posedge clk) needsLongImm);
  c_serial: cover property (@(posedge clk) serialize ##1 flushPending_q ##[1:4] !flushPending_q);
  c_null: cover property (@(posedge clk) wbValid && wbSetFlags && wbReg == REG_NULL);
  c_loop: cover property (@(posedge clk) wbValid && wbReg == REG_LOOP_COUNTER);
  c_error: cover property (@(posedge clk) instrError);
endmodule : core_register_file_decode

/* pipe_model.sv */
// Pipeline stand-in: writeback port and serialize completion
`timescale 1ns/1ps
module pipe_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serialize handshake
  input wire logic [3:0] doneDelay,
  input wire logic serialize,
  output logic serialDone,
  // Writeback
  output logic wbValid,
  output logic [5:0] wbReg,
  output logic [31:0] wbData,
  output logic wbSetFlags,
  output logic [3:0] wbFlags
);
  logic [4:0] waitCnt = 5'h00;
  initial begin
    serialDone = 1'b0;
    wbValid = 1'b0;
    wbReg = 6'h00;
    wbData = 32'h00000000;
    wbSetFlags = 1'b0;
    wbFlags = 4'h0;
  end
  // Done only after the op has run; bench picks a prompt or slow answer
  always @(posedge clk) begin
    if (sys_rst) begin
      waitCnt <= 5'h00;
    end else if (waitCnt != 5'h00) begin
      waitCnt <= waitCnt - 5'h01;
    end else if (serialize) begin
      waitCnt <= {1'b0, doneDelay} + 5'h01;
    end
  end
  always @(negedge clk) serialDone <= (waitCnt == 5'h01);
  task automatic wbDrive(input logic [5:0] r, input logic [31:0] d, input logic sf,
                         input logic [3:0] f);
    wbValid = 1'b1;
    wbReg = r;
    wbData = d;
    wbSetFlags = sf;
    wbFlags = f;
  endtask : wbDrive
  // Released bus shows the inverse so a stale value cannot pass
  task automatic wbIdle();
    wbValid = 1'b0;
    wbSetFlags = 1'b0;
    wbData = ~wbData;
    wbFlags = ~wbFlags;
  endtask : wbIdle
endmodule : pipe_model

/* tb_top.sv */
// Self-checking bench for the register file and operand decode
`timescale 1ns/1ps
module tb_top;
  import core_regfile_pkg::*;
  logic clk, sys_rst, issueValid, isCompact, compactWideField, useStackPtr, isJump;
  logic needsLongImm, condPass, serialize, instrError, wbValid, wbSetFlags, wbIsLoad;
  logic serialDone, flushPending_q, loadDiscarded;
  logic [2:0] compactSrcA, compactSrcB;
  logic [3:0] wbFlags, flags_q, doneDelay;
  logic [4:0] conditionField;
  logic [5:0] srcAField, srcBField, dstField, srcAReg, srcBReg, wbReg;
  logic [15:0] condTruth, extCondTruth;
  logic [31:0] longImmWord, currentPc, srcAData, srcBData, regfileConfigInfo, wbData;
  op_class_e opClass;
  int badCount = 0;
  int testsRun = 0;
  // Full variant so the error paths for reserved and absent registers are live
  core_register_file_decode #(.NUM_REGS(32), .REDUCED(1'b0), .FULL_VARIANT(1'b1)) uut (
    .clk, .sys_rst, .issueValid, .isCompact, .compactWideField, .useStackPtr, .compactSrcA,
    .compactSrcB, .srcAField, .srcBField, .dstField, .longImmWord, .currentPc, .isJump,
    .conditionField, .opClass, .condTruth, .extCondTruth, .srcAReg, .srcBReg, .srcAData,
    .srcBData, .needsLongImm, .condPass, .serialize, .instrError, .regfileConfigInfo,
    .wbValid, .wbReg, .wbData, .wbSetFlags, .wbFlags, .wbIsLoad, .serialDone, .flags_q,
    .flushPending_q, .loadDiscarded);
  pipe_model model (.clk, .sys_rst, .doneDelay, .serialize, .serialDone, .wbValid,
    .wbReg, .wbData, .wbSetFlags, .wbFlags);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [5:0] cmap(int c);
    return (c < 4) ? 6'(c) : 6'(c + 8);
  endfunction : cmap
  function automatic logic [31:0] pat(logic [5:0] r);
    return (r == REG_NULL) ? 32'h00000000 : (32'hC0DE0000 | 32'(r));
  endfunction : pat
  task automatic t_regs();
    logic [5:0] r;
    for (int i = 0; i < 12; i++) begin
      r = (i < 8) ? cmap(i) : 6'(20 + i);
      @(negedge clk);
      model.wbDrive(r, 32'hC0DE0000 | 32'(r), 1'b0, 4'h0);
      srcAField = r;
      #1 chk(srcAData, pat(r), "fwd");
    end
    @(negedge clk);
    model.wbIdle();
    isCompact = 1'b1;
    for (int c = 0; c < 8; c++) begin
      @(negedge clk);
      compactSrcA = 3'(c);
      compactSrcB = 3'(7 - c);
      #1 chk(srcAReg, cmap(c), "mapA");
      chk(srcBReg, cmap(7 - c), "mapB");
      chk(srcAData, pat(cmap(c)), "mapD");
    end
    compactWideField = 1'b1;
    for (int k = 28; k < 32; k++) begin
      @(negedge clk);
      srcAField = 6'(k);
      #1 chk(srcAData, pat(6'(k)), "wide");
    end
    @(negedge clk);
    compactWideField = 1'b0;
    useStackPtr = 1'b1;
    #1 chk(srcAReg, REG_STACK_PTR, "sp");
    chk(srcAData, pat(REG_STACK_PTR), "spD");
    @(negedge clk);
    useStackPtr = 1'b0;
    isCompact = 1'b0;
  endtask : t_regs
  task automatic t_special();
    @(negedge clk);
    model.wbDrive(REG_ALIGNED_PC, 32'hFFFFFFFF, 1'b1, 4'hA);
    srcAField = REG_LONG_IMM;
    srcBField = REG_ALIGNED_PC;
    #1 chk(needsLongImm, 1'b1, "limm");
    chk(srcAData, longImmWord, "limmD");
    chk(srcBData, 32'h12345674, "pcl");
    @(negedge clk);
    model.wbDrive(6'h02, 32'h22222222, 1'b0, 4'h5);
    srcAField = REG_RESERVED;
    #1 chk(instrError, 1'b1, "r61");
    chk(flags_q, 4'hA, "flags");
    @(negedge clk);
    model.wbIdle();
    srcAField = 6'h28;
    #1 chk(instrError, 1'b1, "absent");
    chk(flags_q, 4'hA, "keep");
    chk(srcBData, 32'h12345674, "pclRo");
    @(negedge clk);
    srcAField = REG_NULL;
    #1 chk(instrError, 1'b0, "ok");
    chk(regfileConfigInfo, CONFIG_INFO_FULL, "cfg");
  endtask : t_special
  task automatic t_cond();
    logic [31:0] tv;
    tv = {extCondTruth, condTruth};
    for (int c = 0; c < 32; c++) begin
      @(negedge clk);
      conditionField = 5'(c);
      #1 chk(condPass, tv[c], "cond");
    end
    @(negedge clk);
    isJump = 1'b1;
    isCompact = 1'b1;
    // Condition 2 is false, so only the compact-jump rule can let it pass
    conditionField = 5'h02;
    #1 chk(condPass, 1'b1, "cjmp");
    @(negedge clk);
    isCompact = 1'b0;
    #1 chk(condPass, tv[2], "jcc");
    @(negedge clk);
    isJump = 1'b0;
  endtask : t_cond
  task automatic t_serial();
    for (int k = 0; k < 6; k++) begin
      @(negedge clk);
      opClass = op_class_e'(k);
      doneDelay = 4'(k * 2);
      issueValid = 1'b1;
      #1 chk(serialize, k != 0, "ser");
      @(negedge clk);
      issueValid = 1'b0;
      chk(flushPending_q, k != 0, "flush");
      for (int n = 0; n < 16 && flushPending_q; n++)
        @(negedge clk);
      chk(flushPending_q, 1'b0, "flushEnd");
    end
  endtask : t_serial
  task automatic t_loop();
    @(negedge clk);
    model.wbDrive(REG_LOOP_COUNTER, 32'h00000100, 1'b0, 4'h0);
    srcAField = REG_LOOP_COUNTER;
    srcBField = REG_STACK_PTR;
    #1 chk(srcAData, 32'h00000000, "lpNoFwd");
    @(negedge clk);
    model.wbDrive(REG_NULL, 32'h77777777, 1'b1, 4'h3);
    #1 chk(srcAData, 32'h00000100, "lpWr");
    chk(srcBData, pat(REG_STACK_PTR), "spKeep");
    @(negedge clk);
    model.wbDrive(6'h28, 32'h44444444, 1'b0, 4'h0);
    wbIsLoad = 1'b1;
    srcAField = REG_NULL;
    #1 chk(flags_q, 4'h3, "nullFlags");
    chk(srcAData, 32'h00000000, "nullKeep");
    chk(loadDiscarded, 1'b1, "ldDrop");
    @(negedge clk);
    model.wbIdle();
    wbIsLoad = 1'b0;
    #1 chk(loadDiscarded, 1'b0, "ldIdle");
  endtask : t_loop
  task automatic summarize();
    $display("compares %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  initial begin
    {sys_rst, issueValid} = 2'h3;
    {isCompact, compactWideField, useStackPtr, isJump, wbIsLoad} = 5'h00;
    {compactSrcA, compactSrcB, srcAField, srcBField, dstField} = '0;
    {conditionField, doneDelay} = '0;
    condTruth = 16'hA5C3;
    extCondTruth = 16'h3C5A;
    longImmWord = 32'h5A5AC3C3;
    currentPc = 32'h12345677;
    opClass = OP_PLAIN;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    chk(flags_q, FLAGS_RESET, "rst");
    t_regs();
    t_special();
    t_loop();
    t_cond();
    t_serial();
    summarize();
  end
  initial begin
    repeat (5000) @(posedge clk);
    badCount++;
    summarize();
  end
endmodule : tb_top
